// ### design/sep_params.svh
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// Instruction opcodes.
`define SEP_OP_WRITE_ENABLE 8'h06
`define SEP_OP_WRITE_DISABLE 8'h04
`define SEP_OP_STATUS_READ 8'h05
`define SEP_OP_STATUS_WRITE 8'h01
`define SEP_OP_MEM_READ 8'h03
`define SEP_OP_MEM_WRITE 8'h02

// Status register bit positions, MSB to LSB.
`define SEP_SR_PIN_GUARD_ENABLE 7
`define SEP_SR_ID_PAGE_SELECT 6
`define SEP_SR_ZERO 5
`define SEP_SR_ID_PAGE_LOCK 4
`define SEP_SR_BLOCK_GUARD_HIGH 3
`define SEP_SR_BLOCK_GUARD_LOW 2
`define SEP_SR_WRITE_LATCH 1
`define SEP_SR_BUSY 0
`define SEP_SR_RESET 8'h00

// Array geometry.
`define SEP_ADDR_BITS 15
`define SEP_PAGE_BITS 6
`define SEP_PAGE_BYTES 64
`define SEP_CMD_BITS 8
`define SEP_ADDR_CLOCKS 16

// Block guard ranges: 01 quarter, 10 half, 11 whole array.
`define SEP_GUARD_QUARTER_BASE 15'h6000
`define SEP_GUARD_HALF_BASE 15'h4000
`define SEP_GUARD_NONE 2'h0
`define SEP_GUARD_QUARTER 2'h1
`define SEP_GUARD_HALF 2'h2
`define SEP_GUARD_FULL 2'h3

// Timing: self-timed write cycle and system clock rate.
`define SEP_T_WC_US 5000
`define SEP_SYS_CLK_KHZ 10000
`define SEP_WC_CYCLES ((`SEP_T_WC_US * `SEP_SYS_CLK_KHZ) / 1000)

`endif

// ### design/sep_pkg.sv
package sep_pkg;

    // Serial-side sequencer; Gray codes along opcode, address, data.
    typedef enum logic [2:0]
    {
        SEP_SPI_OPC = 3'h0,
        SEP_SPI_ADDR = 3'h1,
        SEP_SPI_DATA = 3'h3,
        SEP_SPI_OUT = 3'h2,
        SEP_SPI_SRW = 3'h6,
        SEP_SPI_IGN = 3'h4
    } sep_spi_state_t;

    // Self-timed write cycle sequencer.
    typedef enum logic [1:0]
    {
        SEP_WC_IDLE = 2'h0,
        SEP_WC_PROG = 2'h1,
        SEP_WC_WAIT = 2'h3
    } sep_wc_state_t;

    // Decoded command of the current or last frame.
    typedef enum logic [2:0]
    {
        SEP_CMD_NONE = 3'h0,
        SEP_CMD_WRITE_ENABLE_CMD = 3'h1,
        SEP_CMD_WRITE_DISABLE_CMD = 3'h2,
        SEP_CMD_STATUS_READ_CMD = 3'h3,
        SEP_CMD_STATUS_WRITE_CMD = 3'h4,
        SEP_CMD_READ = 3'h5,
        SEP_CMD_WRITE = 3'h6
    } sep_cmd_t;

endpackage

// ### design/sep_pgbuf_if.sv
`timescale 1ns/1ps
`default_nettype none

// Page buffer ports: filled from the serial clock, drained from the system clock.
interface sep_pgbuf_if #(
    parameter int WIDTH = 8,
    parameter int AW = 6
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [WIDTH-1:0] rd_data;

    modport filler (output wr_en, output wr_addr, output wr_data);
    modport drainer (output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ### design/sep_pgbuf.sv
`timescale 1ns/1ps
`default_nettype none

// Two-clock page buffer. Writes and reads never overlap in time: the serial
// side fills it inside a frame, the system side drains it after the frame.
module sep_pgbuf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic wclk,
    input wire logic rclk,
    sep_pgbuf_if.mem pg
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Write port on the serial clock.
    always_ff @(posedge wclk)
    begin
        if (pg.wr_en)
        begin
            mem_reg[pg.wr_addr] <= pg.wr_data;
        end
    end

    // Registered read port on the system clock.
    always_ff @(posedge rclk)
    begin
        pg.rd_data <= mem_reg[pg.rd_addr];
    end
endmodule

`default_nettype wire

// ### design/sep_top.sv
`include "sep_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sep_top #(
    parameter int WC_CYCLES = `SEP_WC_CYCLES,
    parameter int PAGE_BYTES = `SEP_PAGE_BYTES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic spi_so,
    output logic spi_so_oe,
    output logic [`SEP_ADDR_BITS-1:0] arr_raddr,
    output logic arr_rsel_id,
    input wire logic [7:0] arr_rdata,
    output logic [`SEP_ADDR_BITS-1:0] prog_addr,
    output logic prog_id,
    output logic [7:0] prog_data,
    output logic prog_we,
    output logic busy
);
    localparam int PB = `SEP_PAGE_BITS;
    localparam int AB = `SEP_ADDR_BITS;
    localparam int CW = $clog2(WC_CYCLES + 1);

    sep_pgbuf_if #(.WIDTH(8), .AW(PB)) pg ();

    sep_pgbuf #(.WIDTH(8), .DEPTH(PAGE_BYTES)) u_pgbuf (
        .wclk(spi_sck),
        .rclk(sys_clk),
        .pg(pg)
    );

    // Link-side frame state is cleared whenever chip select is high, so a
    // frame always restarts at the opcode and the output is released.
    wire logic frame_rst = rst | spi_cs_n;

    sep_pkg::sep_spi_state_t state_reg;
    sep_pkg::sep_cmd_t cmd_reg;
    logic [3:0] bit_cnt_reg;
    logic [15:0] shift_reg;
    logic [AB-1:0] addr_reg;
    logic [2:0] out_cnt_reg;
    logic [7:0] tx_reg;
    logic so_reg;
    logic so_oe_reg;
    logic [7:0] sr_meta_reg;
    logic [7:0] sr_sync_reg;

    // Frame results, held past the end of the frame for the system side.
    sep_pkg::sep_cmd_t act_cmd_reg;
    logic act_full_reg;
    logic [7:0] act_data_reg;
    logic [AB-1:0] act_addr_reg;
    logic [PAGE_BYTES-1:0] loaded_reg;

    wire logic [7:0] rx_byte = {shift_reg[6:0], spi_si};
    wire logic [15:0] rx_word = {shift_reg[14:0], spi_si};
    wire logic busy_s = sr_sync_reg[`SEP_SR_BUSY];
    wire logic id_sel_s = sr_sync_reg[`SEP_SR_ID_PAGE_SELECT];
    wire logic byte_done = (bit_cnt_reg[2:0] == 3'h7);

    // Opcode decoder; anything but the six opcodes maps to no command.
    function automatic sep_pkg::sep_cmd_t decode(input logic [7:0] op);
        sep_pkg::sep_cmd_t c;
        case (op)
            `SEP_OP_WRITE_ENABLE: c = sep_pkg::SEP_CMD_WRITE_ENABLE_CMD;
            `SEP_OP_WRITE_DISABLE: c = sep_pkg::SEP_CMD_WRITE_DISABLE_CMD;
            `SEP_OP_STATUS_READ: c = sep_pkg::SEP_CMD_STATUS_READ_CMD;
            `SEP_OP_STATUS_WRITE: c = sep_pkg::SEP_CMD_STATUS_WRITE_CMD;
            `SEP_OP_MEM_READ: c = sep_pkg::SEP_CMD_READ;
            `SEP_OP_MEM_WRITE: c = sep_pkg::SEP_CMD_WRITE;
            default: c = sep_pkg::SEP_CMD_NONE;
        endcase
        return c;
    endfunction

    wire sep_pkg::sep_cmd_t op_cmd = decode(rx_byte);
    // While busy every opcode except the status read is dropped.
    wire sep_pkg::sep_cmd_t op_eff = (busy_s && op_cmd != sep_pkg::SEP_CMD_STATUS_READ_CMD) ? sep_pkg::SEP_CMD_NONE : op_cmd;

    // Status register fields.
    logic pgen_reg;
    logic idsel_reg;
    logic lock_reg;
    logic [1:0] guard_reg;
    logic wel_reg;
    logic busy_reg;
    wire logic [7:0] status_q = {pgen_reg, idsel_reg, 1'b0, lock_reg, guard_reg, wel_reg, busy_reg};

    // Status bits brought into the serial clock domain. They settle during
    // the eight opcode clocks, well before any status or read output.
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
        begin
            sr_meta_reg <= `SEP_SR_RESET;
            sr_sync_reg <= `SEP_SR_RESET;
        end
        else
        begin
            sr_meta_reg <= status_q;
            sr_sync_reg <= sr_meta_reg;
        end
    end

    // Rising-edge sequencer: opcode, address, data, status byte, output.
    always_ff @(posedge spi_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            state_reg <= sep_pkg::SEP_SPI_OPC;
            cmd_reg <= sep_pkg::SEP_CMD_NONE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 16'h0000;
            addr_reg <= '0;
            out_cnt_reg <= 3'h0;
        end
        else if (hold_n) // Paused clocks are ignored entirely.
        begin
            shift_reg <= rx_word;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            case (state_reg)
                sep_pkg::SEP_SPI_OPC:
                begin
                    if (byte_done)
                    begin
                        cmd_reg <= op_eff;
                        bit_cnt_reg <= 4'h0;
                        case (op_eff)
                            sep_pkg::SEP_CMD_READ, sep_pkg::SEP_CMD_WRITE: state_reg <= sep_pkg::SEP_SPI_ADDR;
                            sep_pkg::SEP_CMD_STATUS_READ_CMD: state_reg <= sep_pkg::SEP_SPI_OUT;
                            sep_pkg::SEP_CMD_STATUS_WRITE_CMD: state_reg <= sep_pkg::SEP_SPI_SRW;
                            default: state_reg <= sep_pkg::SEP_SPI_IGN;
                        endcase
                    end
                end
                sep_pkg::SEP_SPI_ADDR:
                begin
                    if (bit_cnt_reg == 4'(`SEP_ADDR_CLOCKS - 1))
                    begin
                        // The top address bit is a don't-care.
                        addr_reg <= rx_word[AB-1:0];
                        bit_cnt_reg <= 4'h0;
                        if (cmd_reg == sep_pkg::SEP_CMD_READ)
                        begin
                            state_reg <= sep_pkg::SEP_SPI_OUT;
                        end
                        else
                        begin
                            state_reg <= sep_pkg::SEP_SPI_DATA;
                        end
                    end
                end
                sep_pkg::SEP_SPI_DATA:
                begin
                    if (byte_done)
                    begin
                        // Only the byte-in-page bits advance.
                        addr_reg[PB-1:0] <= addr_reg[PB-1:0] + PB'(1);
                        bit_cnt_reg <= 4'h0;
                    end
                end
                sep_pkg::SEP_SPI_SRW:
                begin
                    if (byte_done)
                    begin
                        state_reg <= sep_pkg::SEP_SPI_IGN;
                    end
                end
                sep_pkg::SEP_SPI_OUT:
                begin
                    out_cnt_reg <= out_cnt_reg + 3'h1;
                    if (out_cnt_reg == 3'h7 && cmd_reg == sep_pkg::SEP_CMD_READ)
                    begin
                        if (id_sel_s)
                        begin
                            addr_reg[PB-1:0] <= addr_reg[PB-1:0] + PB'(1);
                        end
                        else
                        begin
                            addr_reg <= addr_reg + AB'(1);
                        end
                    end
                end
                sep_pkg::SEP_SPI_IGN:
                begin
                    bit_cnt_reg <= 4'h0;
                end
                default: state_reg <= sep_pkg::SEP_SPI_IGN;
            endcase
        end
    end

    // Frame results survive chip select so the system side can act on them.
    // The command, full flag and byte map are wiped at the first clock of the next frame; the host must
    // keep chip select high for three system clocks between frames.
    always_ff @(posedge spi_sck or posedge rst)
    begin
        if (rst)
        begin
            act_cmd_reg <= sep_pkg::SEP_CMD_NONE;
            act_full_reg <= 1'b0;
            act_data_reg <= 8'h00;
            act_addr_reg <= '0;
            loaded_reg <= '0;
        end
        else if (hold_n && !spi_cs_n)
        begin
            if (state_reg == sep_pkg::SEP_SPI_OPC && bit_cnt_reg == 4'h0)
            begin
                act_cmd_reg <= sep_pkg::SEP_CMD_NONE;
                act_full_reg <= 1'b0;
                loaded_reg <= '0;
            end
            else if (state_reg == sep_pkg::SEP_SPI_OPC && byte_done)
            begin
                act_cmd_reg <= op_eff;
            end
            else if (state_reg == sep_pkg::SEP_SPI_ADDR && bit_cnt_reg == 4'(`SEP_ADDR_CLOCKS - 1))
            begin
                act_addr_reg <= rx_word[AB-1:0];
            end
            else if (state_reg == sep_pkg::SEP_SPI_DATA && byte_done)
            begin
                loaded_reg[addr_reg[PB-1:0]] <= 1'b1;
                act_full_reg <= 1'b1;
            end
            else if (state_reg == sep_pkg::SEP_SPI_SRW && byte_done)
            begin
                act_data_reg <= rx_byte;
                act_full_reg <= 1'b1;
            end
        end
    end

    // Page loading writes each completed data byte into the page buffer.
    assign pg.wr_en = hold_n && state_reg == sep_pkg::SEP_SPI_DATA && byte_done;
    assign pg.wr_addr = addr_reg[PB-1:0];
    assign pg.wr_data = rx_byte;

    // Falling-edge output shifter. The array read data must be valid half a
    // serial clock after the address changes. Hold releases the pin at the
    // next falling edge, a limitation of driving the output from a register.
    wire logic [7:0] tx_src = (cmd_reg == sep_pkg::SEP_CMD_STATUS_READ_CMD) ? sr_sync_reg : arr_rdata;
    always_ff @(negedge spi_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
            tx_reg <= 8'h00;
        end
        else if (!hold_n)
        begin
            so_oe_reg <= 1'b0;
        end
        else if (state_reg == sep_pkg::SEP_SPI_OUT)
        begin
            so_oe_reg <= 1'b1;
            if (out_cnt_reg == 3'h0)
            begin
                so_reg <= tx_src[7];
                tx_reg <= {tx_src[6:0], 1'b0};
            end
            else
            begin
                so_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    assign spi_so = so_reg;
    assign spi_so_oe = so_oe_reg;
    assign arr_raddr = addr_reg;
    assign arr_rsel_id = id_sel_s;

    // System side: chip select and protect pin pass two flip-flops.
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_last_reg;
    logic wp_meta_reg;
    logic wp_sync_reg;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_last_reg <= 1'b1;
            wp_meta_reg <= 1'b1;
            wp_sync_reg <= 1'b1;
        end
        else
        begin
            cs_meta_reg <= spi_cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_last_reg <= cs_sync_reg;
            wp_meta_reg <= wp_n;
            wp_sync_reg <= wp_meta_reg;
        end
    end
    wire logic frame_end = cs_sync_reg & ~cs_last_reg;

    // Permission checks, evaluated on the frame that just closed.
    wire logic hw_prot = pgen_reg & ~wp_sync_reg;
    logic guarded;
    always_comb
    begin
        case (guard_reg)
            `SEP_GUARD_QUARTER: guarded = act_addr_reg >= `SEP_GUARD_QUARTER_BASE;
            `SEP_GUARD_HALF: guarded = act_addr_reg >= `SEP_GUARD_HALF_BASE;
            `SEP_GUARD_FULL: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    end
    wire logic mem_ok = wel_reg & ~guarded & (~idsel_reg | (~lock_reg & guard_reg != `SEP_GUARD_FULL));
    wire logic sr_ok = wel_reg & ~hw_prot;
    wire logic go_write = frame_end && !busy_reg && act_cmd_reg == sep_pkg::SEP_CMD_WRITE && act_full_reg && mem_ok;
    wire logic go_status = frame_end && !busy_reg && act_cmd_reg == sep_pkg::SEP_CMD_STATUS_WRITE_CMD && act_full_reg && sr_ok;
    wire logic both_id = act_data_reg[`SEP_SR_ID_PAGE_SELECT] & act_data_reg[`SEP_SR_ID_PAGE_LOCK];

    sep_pkg::sep_wc_state_t wc_state_reg;
    logic [CW-1:0] wc_cnt_reg;
    logic [PB:0] idx_reg;
    logic [PB-1:0] idx_d_reg;
    logic vld_d_reg;
    logic [AB-1:0] page_reg;
    logic page_id_reg;
    logic [PAGE_BYTES-1:0] mask_reg;
    wire logic wc_done = wc_cnt_reg == CW'(WC_CYCLES - 1);

    // Status register updates from commands and the write cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pgen_reg <= 1'b0;
            idsel_reg <= 1'b0;
            lock_reg <= 1'b0;
            guard_reg <= `SEP_GUARD_NONE;
            wel_reg <= 1'b0;
        end
        else if (wc_state_reg == sep_pkg::SEP_WC_WAIT && wc_done)
        begin
            wel_reg <= 1'b0;
        end
        else if (frame_end && !busy_reg)
        begin
            case (act_cmd_reg)
                sep_pkg::SEP_CMD_WRITE_ENABLE_CMD: wel_reg <= 1'b1;
                sep_pkg::SEP_CMD_WRITE_DISABLE_CMD: wel_reg <= 1'b0;
                sep_pkg::SEP_CMD_READ, sep_pkg::SEP_CMD_WRITE: idsel_reg <= 1'b0;
                sep_pkg::SEP_CMD_STATUS_WRITE_CMD:
                begin
                    if (go_status)
                    begin
                        pgen_reg <= act_data_reg[`SEP_SR_PIN_GUARD_ENABLE];
                        guard_reg <= act_data_reg[`SEP_SR_BLOCK_GUARD_HIGH:`SEP_SR_BLOCK_GUARD_LOW];
                        if (!both_id)
                        begin
                            idsel_reg <= act_data_reg[`SEP_SR_ID_PAGE_SELECT];
                            lock_reg <= lock_reg | act_data_reg[`SEP_SR_ID_PAGE_LOCK];
                        end
                    end
                end
                default: wel_reg <= wel_reg;
            endcase
        end
    end

    // Self-timed write cycle: drain loaded bytes, then wait out the time.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wc_state_reg <= sep_pkg::SEP_WC_IDLE;
            busy_reg <= 1'b0;
            wc_cnt_reg <= '0;
            idx_reg <= '0;
            page_reg <= '0;
            page_id_reg <= 1'b0;
            mask_reg <= '0;
        end
        else
        begin
            case (wc_state_reg)
                sep_pkg::SEP_WC_IDLE:
                begin
                    wc_cnt_reg <= '0;
                    idx_reg <= '0;
                    if (go_write || go_status)
                    begin
                        busy_reg <= 1'b1;
                        page_reg <= act_addr_reg;
                        page_id_reg <= idsel_reg;
                        // A status poll during the cycle wipes the frame results, so keep the byte map.
                        mask_reg <= loaded_reg;
                        wc_state_reg <= go_write ? sep_pkg::SEP_WC_PROG : sep_pkg::SEP_WC_WAIT;
                    end
                end
                sep_pkg::SEP_WC_PROG:
                begin
                    wc_cnt_reg <= wc_cnt_reg + CW'(1);
                    idx_reg <= idx_reg + (PB + 1)'(1);
                    if (idx_reg == (PB + 1)'(PAGE_BYTES - 1))
                    begin
                        wc_state_reg <= sep_pkg::SEP_WC_WAIT;
                    end
                end
                sep_pkg::SEP_WC_WAIT:
                begin
                    wc_cnt_reg <= wc_cnt_reg + CW'(1);
                    if (wc_done)
                    begin
                        busy_reg <= 1'b0;
                        wc_state_reg <= sep_pkg::SEP_WC_IDLE;
                    end
                end
                default: wc_state_reg <= sep_pkg::SEP_WC_IDLE;
            endcase
        end
    end

    // Buffer drain pipeline: address, registered data, then the program port.
    assign pg.rd_addr = idx_reg[PB-1:0];
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            idx_d_reg <= '0;
            vld_d_reg <= 1'b0;
            prog_we <= 1'b0;
            prog_addr <= '0;
            prog_id <= 1'b0;
            prog_data <= 8'h00;
        end
        else
        begin
            idx_d_reg <= idx_reg[PB-1:0];
            vld_d_reg <= wc_state_reg == sep_pkg::SEP_WC_PROG && mask_reg[idx_reg[PB-1:0]];
            prog_we <= vld_d_reg;
            prog_addr <= {page_reg[AB-1:PB], idx_d_reg};
            prog_id <= page_id_reg;
            prog_data <= pg.rd_data;
        end
    end

    assign busy = busy_reg;
endmodule

`default_nettype wire

// ### verif/sep_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sep_chk #(
    parameter int WC_CYCLES = 40
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic prog_we,
    input wire logic busy
);
    int busy_cnt;
    logic [7:0] sck_cnt;
    logic so_rise;
    // Busy length is counted, since a repetition cannot hold the full cycle count.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            busy_cnt <= 0;
        else
            busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
    // Bits seen in the frame; deselect clears the count at once.
    always_ff @(posedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            sck_cnt <= 8'h00;
        else
            sck_cnt <= sck_cnt + 8'h01;
    end
    // Output level at each rising edge, so a move before the falling edge shows.
    always_ff @(posedge spi_sck)
    begin
        so_rise <= spi_so;
    end
    sequence s_frame_closed;
        spi_cs_n && $past(spi_cs_n, 2);
    endsequence
    AST_SO_RELEASED: assert property (@(posedge sys_clk) disable iff (rst) spi_cs_n |-> !spi_so_oe)
        else $error("output driven while deselected");
    AST_RESET_QUIET: assert property (@(posedge sys_clk) rst |-> !busy && !prog_we)
        else $error("activity during reset");
    AST_BUSY_LEN: assert property (@(posedge sys_clk) disable iff (rst) $fell(busy) |-> busy_cnt >= WC_CYCLES && busy_cnt <= WC_CYCLES + 1)
        else $error("write cycle length wrong");
    AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (rst) $rose(busy) |=> busy [*8])
        else $error("busy dropped early");
    AST_PROG_IN_BUSY: assert property (@(posedge sys_clk) disable iff (rst) prog_we |-> busy)
        else $error("programming outside write cycle");
    AST_BUSY_AFTER_CS: assert property (@(posedge sys_clk) disable iff (rst) $rose(busy) |-> s_frame_closed)
        else $error("write cycle started inside a frame");
    AST_SO_FALL_ONLY: assert property (@(negedge spi_sck) disable iff (rst || spi_cs_n) spi_so_oe |-> spi_so == so_rise)
        else $error("output moved on rising edge");
    AST_OE_AFTER_OPCODE: assert property (@(negedge spi_sck) disable iff (rst || spi_cs_n) $rose(spi_so_oe) |-> sck_cnt >= 8'h08)
        else $error("output before opcode complete");
endmodule
`default_nettype wire

// ### verif/sep_host.sv
`timescale 1ns/1ps
`default_nettype none
module sep_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    logic b = 1'b0;
    int hold_at = -1;
    // Clock rests low between frames; hold stays high unless a pause is asked for.
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // Sends n bits of v MSB first; a released line reads as the inverse of its last level.
    task automatic xf(input logic [63:0] v, input int n, output logic [15:0] r);
        r = 16'h0000;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            if (i == hold_at)
            begin
                // One clock pulse inside the pause must be ignored.
                #12 hold_n = 1'b0;
                #24 sck = 1'b1;
                #24 sck = 1'b0;
                #12 hold_n = 1'b1;
            end
            si = v[63-i];
            #24 sck = 1'b1;
            b = so_oe ? so : ~b;
            r = {r[14:0], b};
            #24 sck = 1'b0;
        end
        #24 cs_n = 1'b1;
        #500;
    endtask
endmodule
`default_nettype wire

// ### verif/spi_eeprom_command_protect_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_protect_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic spi_sck, spi_cs_n, spi_si, hold_n, spi_so, spi_so_oe, arr_rsel_id, prog_id, prog_we, busy;
    logic [14:0] arr_raddr, prog_addr;
    logic [7:0] prog_data;
    logic [15:0] r;
    logic [7:0] pm[logic [14:0]];
    int np = 0;
    logic pid = 1'b0;
    int errors = 0;
    int checks_done = 0;
    // The array answers at once with a byte made from the low address byte and the ID select.
    wire logic [7:0] arr_rdata = arr_raddr[7:0] ^ (arr_rsel_id ? 8'hA5 : 8'h3C);
    // The write cycle must outlast the 64-cycle page drain.
    sep_top #(.WC_CYCLES(100)) i_dut (.sys_clk, .rst, .spi_sck, .spi_cs_n, .spi_si, .hold_n, .wp_n, .spi_so,
        .spi_so_oe, .arr_raddr, .arr_rsel_id, .arr_rdata, .prog_addr, .prog_id, .prog_data, .prog_we, .busy);
    sep_host i_host (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si), .hold_n, .so(spi_so), .so_oe(spi_so_oe));
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Programmed bytes are kept by address, as they come out in page index order, not in the order sent.
    always @(posedge sys_clk)
    begin
        if (prog_we === 1'b1)
        begin
            pm[prog_addr] = prog_data;
            pid = prog_id;
            np++;
        end
    end
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic op(input logic [7:0] c);
        i_host.xf({c, 56'h0}, 8, r);
    endtask
    task automatic sr(input logic [7:0] e);
        i_host.xf({8'h05, 56'h0}, 16, r);
        cmp("status", e, r[7:0]);
    endtask
    task automatic wbusy();
        for (int i = 0; i < 300 && busy !== 1'b0; i++)
            @(posedge sys_clk);
        cmp("idle", 16'h0, busy);
    endtask
    task automatic sw(input logic [7:0] v);
        op(8'h06);
        i_host.xf({8'h01, v, 48'h0}, 16, r);
        wbusy();
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        i_host.xf({8'h02, 1'b0, a, d, 24'h0}, 40, r);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #400000;
        errors++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        sr(8'h00);
        i_host.hold_at = 3;
        op(8'h06);
        i_host.hold_at = -1;
        sr(8'h02);
        op(8'h04);
        sr(8'h00);
        wr(15'h0010, 16'h1122);
        cmp("busy", 16'h0, busy);
        op(8'h06);
        wr(15'h003F, 16'hA55A);
        op(8'h04);
        sr(8'h03);
        wbusy();
        sr(8'h00);
        cmp("prog", 16'hA5, pm[15'h003F]);
        cmp("prog", 16'h5A, pm[15'h0000]);
        sw(8'h8C);
        sr(8'h8C);
        @(posedge sys_clk) wp_n <= 1'b0;
        sw(8'h00);
        sr(8'h8E);
        @(posedge sys_clk) wp_n <= 1'b1;
        sw(8'h54);
        sr(8'h04);
        op(8'h06);
        wr(15'h6000, 16'h7788);
        cmp("busy", 16'h0, busy);
        wr(15'h5FFF, 16'h99AA);
        wbusy();
        cmp("prog", 16'h99, pm[15'h5FFF]);
        cmp("prog", 16'hAA, pm[15'h5FC0]);
        cmp("count", 16'h4, np[15:0]);
        i_host.xf({8'h03, 16'h7FFF, 40'h0}, 40, r);
        cmp("read", 16'hC33C, r);
        i_host.xf({8'hFF, 8'h06, 48'h0}, 16, r);
        sr(8'h04);
        sw(8'h44);
        i_host.xf({8'h03, 16'h7FFF, 40'h0}, 40, r);
        cmp("id read", 16'h5A65, r);
        sr(8'h04);
        sw(8'h44);
        op(8'h06);
        wr(15'h0001, 16'hBEEF);
        wbusy();
        cmp("prog_id", 16'h1, pid);
        cmp("prog", 16'hEF, pm[15'h0002]);
        sw(8'h14);
        sw(8'h44);
        op(8'h06);
        wr(15'h0001, 16'h0000);
        cmp("busy", 16'h0, busy);
        sr(8'h16);
        end_of_test();
    end
endmodule
bind sep_top sep_chk #(.WC_CYCLES(WC_CYCLES)) i_chk (.sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .prog_we(prog_we), .busy(busy));
`default_nettype wire
